// *** core/ads_pkg.sv ***
/*
  Shared constants and types for the attenuator DAC code stepper.
  Assumes a single 20 MHz core clock and pins sampled through synchronisers.
*/
package ads_pkg;

  // ----------------------------------------
  // Code and SPI frame
  // ----------------------------------------
  localparam int CODE_W = 10;
  localparam int SPI_BITS = 13;
  localparam logic [3:0] SPI_LAST_IDX = 4'hc;
  localparam logic [3:0] SPI_CNT_RST = 4'h0;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [9:0] REG_RST = 10'h000;
  localparam logic [1:0] ADDR_CODE = 2'h0;
  localparam logic [1:0] ADDR_UP = 2'h1;
  localparam logic [1:0] ADDR_DOWN = 2'h2;
  localparam logic [1:0] ADDR_CFG = 2'h3;
  localparam int RDBK_BIT = 9;

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  localparam int PIN_N = 7;
  localparam int PIN_MODE = 0;
  localparam int PIN_UP = 1;
  localparam int PIN_DOWN = 2;
  localparam int PIN_REF = 3;
  localparam int PIN_SCLK = 4;
  localparam int PIN_DIN = 5;
  localparam int PIN_CS = 6;
  // Step pins and chip select idle high
  localparam logic [6:0] PIN_IDLE = 7'h46;

  typedef logic [9:0] ads_code_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_SHIFT = 2'b01,
    SPI_FULL = 2'b10,
    SPI_OVER = 2'b11
  } ads_spi_st_e;

  typedef struct packed {
    logic rw;
    logic [1:0] addr;
    logic [9:0] data;
  } ads_frame_s;

  typedef struct packed {
    logic cs_n;
    logic din;
    logic sclk;
    logic ref_sel;
    logic step_down_pin;
    logic step_up_pin;
    logic mode;
  } ads_pins_s;

endpackage : ads_pkg

// *** core/ads_stepper.sv ***
/*
  Attenuator DAC code holder and step engine with its SPI write latch.
  Assumes all pins are asynchronous to core_clk and change slowly
  against it; every level must hold at least two clock cycles.
*/
`timescale 1ns/1ps

// What this block does
// - With mode low the DAC code follows the code register and the step pins are ignored.
// - With mode high the DAC code changes only through step pin activity.
// - In step mode the step-up amount register sets each increment.
// - In step mode the step-down amount register sets each decrement.
// - In step mode both step pins low force the DAC code to zero.
// - A low pulse on step-up while step-down is high adds the step-up amount.
// - A low pulse on step-down while step-up is high subtracts the step-down amount.
// - Stepping saturates at the code maximum and at zero without wrapping.
// - Reference select low picks the internal DAC reference.
// - Reference select high picks the external reference pin.
// - A 13-bit write lands in the addressed register only on chip-select rising.
module ads_stepper (
  input logic core_clk,
  input logic reset_n,
  input ads_pkg::ads_pins_s pin_in,
  output ads_pkg::ads_code_t dac_code_reg,
  output logic ext_ref_sel_reg,
  output logic readback_en_reg,
  output logic step_mode_reg
);
  import ads_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_reg;
  logic [PIN_N-1:0] s2_reg;
  logic [PIN_N-1:0] s3_reg;
  logic [PIN_N-1:0] lvl_reg;
  logic [PIN_N-1:0] prev_reg;
  logic [PIN_N-1:0] agree;
  logic [PIN_N-1:0] lvl_next;
  logic [PIN_N-1:0] rise;

  assign pin_raw = pin_in;
  // Level moves only when the last two stages agree, so a runt is dropped
  assign agree = ~(s2_reg ^ s3_reg);
  assign lvl_next = (s3_reg & agree) | (lvl_reg & ~agree);
  assign rise = lvl_reg & ~prev_reg;

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      lvl_reg <= PIN_IDLE;
      prev_reg <= PIN_IDLE;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
      prev_reg <= lvl_reg;
    end
  end

  logic mode_lvl;
  logic up_lvl;
  logic dn_lvl;
  logic ref_lvl;
  logic din_lvl;
  logic cs_lvl;
  logic up_rise;
  logic dn_rise;
  logic sclk_rise;
  logic cs_rise;

  assign mode_lvl = lvl_reg[PIN_MODE];
  assign up_lvl = lvl_reg[PIN_UP];
  assign dn_lvl = lvl_reg[PIN_DOWN];
  assign ref_lvl = lvl_reg[PIN_REF];
  assign din_lvl = lvl_reg[PIN_DIN];
  assign cs_lvl = lvl_reg[PIN_CS];
  // One step per pulse, taken on the return to high
  assign up_rise = rise[PIN_UP];
  assign dn_rise = rise[PIN_DOWN];
  assign sclk_rise = rise[PIN_SCLK];
  assign cs_rise = rise[PIN_CS];

  // ----------------------------------------
  // SPI write latch
  // ----------------------------------------
  ads_spi_st_e spi_st_reg;
  ads_spi_st_e spi_st_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  ads_frame_s frame_reg;
  ads_frame_s frame_next;
  logic [SPI_BITS-1:0] frame_shift;
  logic wr_go;
  logic wr_code;
  logic wr_up;
  logic wr_down;
  logic wr_cfg;
  ads_code_t code0_reg;
  ads_code_t step_up_reg;
  ads_code_t step_down_reg;

  function automatic logic addr_hit(input ads_frame_s f, input logic [1:0] a);
    return f.addr == a;
  endfunction : addr_hit

  assign frame_shift = {frame_reg[SPI_BITS-2:0], din_lvl};
  // Short or long frames never reach the registers
  assign wr_go = cs_rise && (spi_st_reg == SPI_FULL) && !frame_reg.rw;
  assign wr_code = wr_go && addr_hit(frame_reg, ADDR_CODE);
  assign wr_up = wr_go && addr_hit(frame_reg, ADDR_UP);
  assign wr_down = wr_go && addr_hit(frame_reg, ADDR_DOWN);
  assign wr_cfg = wr_go && addr_hit(frame_reg, ADDR_CFG);

  always_comb begin
    spi_st_next = spi_st_reg;
    bit_cnt_next = bit_cnt_reg;
    frame_next = frame_reg;
    if (cs_lvl) begin
      spi_st_next = SPI_IDLE;
      bit_cnt_next = SPI_CNT_RST;
    end else if (sclk_rise) begin
      case (spi_st_reg)
        SPI_IDLE, SPI_SHIFT: begin
          frame_next = ads_frame_s'(frame_shift);
          bit_cnt_next = bit_cnt_reg + 4'h1;
          spi_st_next = (bit_cnt_reg == SPI_LAST_IDX) ? SPI_FULL : SPI_SHIFT;
        end
        default: begin
          spi_st_next = SPI_OVER;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      spi_st_reg <= SPI_IDLE;
      bit_cnt_reg <= SPI_CNT_RST;
      frame_reg <= '0;
    end else begin
      spi_st_reg <= spi_st_next;
      bit_cnt_reg <= bit_cnt_next;
      frame_reg <= frame_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      code0_reg <= REG_RST;
      step_up_reg <= REG_RST;
      step_down_reg <= REG_RST;
      readback_en_reg <= 1'b0;
    end else begin
      if (wr_code) code0_reg <= frame_reg.data;
      if (wr_up) step_up_reg <= frame_reg.data;
      if (wr_down) step_down_reg <= frame_reg.data;
      if (wr_cfg) readback_en_reg <= frame_reg.data[RDBK_BIT];
    end
  end

  // ----------------------------------------
  // Step engine
  // ----------------------------------------
  logic [CODE_W:0] up_sum;
  logic [CODE_W:0] dn_diff;
  ads_code_t up_clamped;
  ads_code_t dn_clamped;
  ads_code_t step_next;
  ads_code_t code_next;
  logic both_low;
  logic do_up;
  logic do_dn;

  // Extra carry bit catches overflow and borrow without wrapping
  assign up_sum = {1'b0, dac_code_reg} + {1'b0, step_up_reg};
  assign dn_diff = {1'b0, dac_code_reg} - {1'b0, step_down_reg};
  assign up_clamped = up_sum[CODE_W] ? CODE_MAX : up_sum[CODE_W-1:0];
  assign dn_clamped = dn_diff[CODE_W] ? CODE_ZERO : dn_diff[CODE_W-1:0];
  assign both_low = !up_lvl && !dn_lvl;
  // Simultaneous releases give priority to the increment
  assign do_up = up_rise && dn_lvl;
  assign do_dn = dn_rise && up_lvl;
  assign step_next = both_low ? CODE_ZERO :
                     do_up ? up_clamped :
                     do_dn ? dn_clamped :
                     dac_code_reg;
  // Entering step mode starts from the current register code
  assign code_next = mode_lvl ? step_next : code0_reg;

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dac_code_reg <= CODE_ZERO;
      ext_ref_sel_reg <= 1'b0;
      step_mode_reg <= 1'b0;
    end else begin
      dac_code_reg <= code_next;
      ext_ref_sel_reg <= ref_lvl;
      step_mode_reg <= mode_lvl;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n_reg);

  a_spi_mode_code:
    assert property (!mode_lvl |=> dac_code_reg == $past(code0_reg))
    else $error("DAC code does not follow the code register");
  a_step_code_hold:
    assert property ((mode_lvl && !both_low && !up_rise && !dn_rise) |=> $stable(dac_code_reg))
    else $error("DAC code moved without step activity");
  a_up_amount_reg:
    assert property ((mode_lvl && do_up && dac_code_reg == CODE_ZERO)
      |=> dac_code_reg == $past(step_up_reg))
    else $error("Increment does not use the step-up amount");
  a_down_amount_reg:
    assert property ((mode_lvl && do_dn && dac_code_reg == CODE_MAX)
      |=> dac_code_reg == CODE_MAX - $past(step_down_reg))
    else $error("Decrement does not use the step-down amount");
  a_both_low_clear:
    assert property ((mode_lvl && !up_lvl && !dn_lvl) |=> dac_code_reg == CODE_ZERO)
    else $error("Both step pins low did not clear the code");
  a_step_up_add:
    assert property ((mode_lvl && up_rise && dn_lvl && dac_code_reg <= CODE_MAX - step_up_reg)
      |=> dac_code_reg == $past(dac_code_reg) + $past(step_up_reg))
    else $error("Step-up pulse did not add its amount");
  a_step_down_sub:
    assert property ((mode_lvl && dn_rise && up_lvl && dac_code_reg >= step_down_reg)
      |=> dac_code_reg == $past(dac_code_reg) - $past(step_down_reg))
    else $error("Step-down pulse did not subtract its amount");
  a_up_saturate:
    assert property ((mode_lvl && do_up && dac_code_reg > CODE_MAX - step_up_reg)
      |=> dac_code_reg == CODE_MAX)
    else $error("Increment did not saturate at maximum");
  a_down_saturate:
    assert property ((mode_lvl && do_dn && dac_code_reg < step_down_reg)
      |=> dac_code_reg == CODE_ZERO)
    else $error("Decrement did not saturate at zero");
  a_ref_internal:
    assert property (!ref_lvl |=> !ext_ref_sel_reg)
    else $error("Internal reference not selected");
  a_ref_external:
    assert property (ref_lvl |=> ext_ref_sel_reg)
    else $error("External reference not selected");
  a_spi_write_latch:
    assert property ((cs_rise && spi_st_reg == SPI_FULL && !frame_reg.rw
      && frame_reg.addr == ADDR_UP) |=> step_up_reg == $past(frame_reg.data))
    else $error("Full write frame not latched on chip-select rise");
  a_short_frame_drop:
    assert property ((cs_rise && spi_st_reg != SPI_FULL)
      |=> $stable(code0_reg) && $stable(step_up_reg) && $stable(step_down_reg))
    else $error("Incomplete frame changed a register");
  a_single_step_pulse:
    assert property (up_rise |=> !up_rise ##1 !up_rise)
    else $error("One pulse produced more than one step");
  a_mode_flag_follow:
    assert property (mode_lvl |=> step_mode_reg)
    else $error("Step mode flag not raised in step mode");
  a_spi_mode_flag:
    assert property (!mode_lvl |=> !step_mode_reg)
    else $error("Step mode flag raised in register mode");
  a_code_write_latch:
    assert property (wr_code |=> code0_reg == $past(frame_reg.data))
    else $error("Code register write not latched");
  a_down_write_latch:
    assert property (wr_down |=> step_down_reg == $past(frame_reg.data))
    else $error("Step-down amount write not latched");
  a_cfg_bit_set:
    assert property ((wr_cfg && frame_reg.data[RDBK_BIT]) |=> readback_en_reg)
    else $error("Readback enable not set by write");
  a_cfg_bit_clear:
    assert property ((wr_cfg && !frame_reg.data[RDBK_BIT]) |=> !readback_en_reg)
    else $error("Readback enable not cleared by write");
  a_read_frame_drop:
    assert property ((cs_rise && frame_reg.rw)
      |=> $stable(code0_reg) && $stable(step_up_reg) && $stable(step_down_reg))
    else $error("Read frame changed a register");
  a_step_refused:
    assert property ((mode_lvl && up_rise && !dn_lvl) |=> $stable(dac_code_reg))
    else $error("Step-up release with step-down low moved the code");
  a_code_no_wrap:
    assert property ((mode_lvl && do_up) |=> dac_code_reg >= $past(dac_code_reg))
    else $error("Increment wrapped the code");
  a_code_no_borrow:
    assert property ((mode_lvl && do_dn && !do_up) |=> dac_code_reg <= $past(dac_code_reg))
    else $error("Decrement wrapped the code");

endmodule : ads_stepper

// *** verif/ads_ctrl_model.sv ***
/*
  Behavioural external controller for the attenuator DAC code stepper.
  Assumes the bench calls its tasks from the falling edge of core_clk.
*/
`timescale 1ns/1ps

module ads_ctrl_model (
  input wire logic core_clk,
  output ads_pkg::ads_pins_s pins
);
  import ads_pkg::*;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  initial pins = PIN_IDLE;

  // Four cycles, two more than the filter needs
  task automatic hold_pins();
    repeat (4) @(negedge core_clk);
  endtask : hold_pins

  task automatic set_level(input int idx, input logic v);
    pins[idx] = v;
    hold_pins();
  endtask : set_level

  // Short frames are sent by giving fewer bits
  task automatic spi_write(input logic rw, input logic [1:0] addr,
                           input logic [9:0] data, input int nbits);
    logic [12:0] word;
    word = {rw, addr, data};
    pins.cs_n = 1'b0;
    hold_pins();
    for (int i = 12; i > 12 - nbits; i--) begin
      // Bits past the word go out as zero
      pins.din = (i >= 0) ? word[i] : 1'b0;
      hold_pins();
      pins.sclk = 1'b1;
      hold_pins();
      pins.sclk = 1'b0;
    end
    hold_pins();
    pins.cs_n = 1'b1;
    // Released data line must not keep its last value
    pins.din = ~pins.din;
    hold_pins();
  endtask : spi_write

  task automatic step_pulse(input logic up);
    if (up) pins.step_up_pin = 1'b0;
    else pins.step_down_pin = 1'b0;
    hold_pins();
    pins.step_up_pin = 1'b1;
    pins.step_down_pin = 1'b1;
    hold_pins();
  endtask : step_pulse

endmodule : ads_ctrl_model

// *** verif/attenuator_dac_code_stepper_tb.sv ***
/*
  Self-checking bench for the attenuator DAC code stepper.
  Assumes the controller model drives every pin; reset comes from here.
*/
`timescale 1ns/1ps

module attenuator_dac_code_stepper_tb;
  import ads_pkg::*;

  localparam ads_code_t UPV = 10'h100;
  localparam ads_code_t DNV = 10'h0c0;
  logic core_clk;
  logic reset_n;
  ads_pins_s pin_in;
  ads_code_t dac_code_reg;
  logic ext_ref_sel_reg;
  logic readback_en_reg;
  logic step_mode_reg;
  int fail_count;
  int compares;
  int cycles;
  ads_code_t exp_code;

  // ----------------------------------------
  // Clock, parts and timeout
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ads_ctrl_model ctrl (.core_clk(core_clk), .pins(pin_in));

  ads_stepper DUT (.core_clk(core_clk), .reset_n(reset_n), .pin_in(pin_in),
    .dac_code_reg(dac_code_reg), .ext_ref_sel_reg(ext_ref_sel_reg),
    .readback_en_reg(readback_en_reg), .step_mode_reg(step_mode_reg));

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      wrap_up();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] expv);
    compares++;
    if (seen !== expv) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic settle();
    repeat (8) @(negedge core_clk);
  endtask : settle

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_spi();
    ctrl.spi_write(1'b0, ADDR_CODE, 10'h2a5, 13);
    settle();
    check(dac_code_reg, 10'h2a5);
    ctrl.spi_write(1'b0, ADDR_CODE, 10'h155, 12);
    settle();
    check(dac_code_reg, 10'h2a5);
    ctrl.spi_write(1'b1, ADDR_CODE, 10'h155, 13);
    settle();
    check(dac_code_reg, 10'h2a5);
    ctrl.spi_write(1'b0, ADDR_CODE, 10'h155, 14);
    settle();
    check(dac_code_reg, 10'h2a5);
    ctrl.step_pulse(1'b1);
    ctrl.step_pulse(1'b0);
    settle();
    check(dac_code_reg, 10'h2a5);
    ctrl.spi_write(1'b0, ADDR_CFG, 10'h200, 13);
    settle();
    check({9'h000, readback_en_reg}, 10'h001);
    ctrl.spi_write(1'b0, ADDR_UP, UPV, 13);
    ctrl.spi_write(1'b0, ADDR_DOWN, DNV, 13);
  endtask : test_spi

  task automatic test_ref();
    ctrl.set_level(PIN_REF, 1'b1);
    settle();
    check({9'h000, ext_ref_sel_reg}, 10'h001);
    ctrl.set_level(PIN_REF, 1'b0);
    settle();
    check({9'h000, ext_ref_sel_reg}, 10'h000);
  endtask : test_ref

  task automatic test_step();
    ctrl.set_level(PIN_MODE, 1'b1);
    settle();
    check({9'h000, step_mode_reg}, 10'h001);
    exp_code = 10'h2a5;
    for (int i = 0; i < 3; i++) begin
      ctrl.step_pulse(1'b1);
      settle();
      exp_code = (exp_code > CODE_MAX - UPV) ? CODE_MAX : exp_code + UPV;
      check(dac_code_reg, exp_code);
    end
    for (int i = 0; i < 6; i++) begin
      ctrl.step_pulse(1'b0);
      settle();
      exp_code = (exp_code < DNV) ? CODE_ZERO : exp_code - DNV;
      check(dac_code_reg, exp_code);
    end
    ctrl.spi_write(1'b0, ADDR_CODE, 10'h1c3, 13);
    ctrl.step_pulse(1'b1);
    settle();
    check(dac_code_reg, UPV);
    ctrl.set_level(PIN_UP, 1'b0);
    ctrl.set_level(PIN_DOWN, 1'b0);
    settle();
    check(dac_code_reg, CODE_ZERO);
    ctrl.set_level(PIN_UP, 1'b1);
    ctrl.set_level(PIN_DOWN, 1'b1);
    settle();
    check(dac_code_reg, CODE_ZERO);
    ctrl.set_level(PIN_MODE, 1'b0);
    settle();
    check(dac_code_reg, 10'h1c3);
    check({9'h000, step_mode_reg}, 10'h000);
  endtask : test_step

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    compares = 0;
    cycles = 0;
    reset_n = 1'b0;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    settle();
    check(dac_code_reg, REG_RST);
    test_spi();
    test_ref();
    test_step();
    wrap_up();
  end

endmodule : attenuator_dac_code_stepper_tb
